/* common/ccec_pkg.sv */
/*
 * Constants and types shared by the control channel error control block.
 * Assumes a single core clock and an on-chip register access port decoded elsewhere.
 */
package ccec_pkg;

	// ************************************************
	// Register map
	// ************************************************
	localparam logic [7:0] ERR_CTL_OFFSET  = 8'h46;
	localparam logic [7:0] PORT_SEL_OFFSET = 8'h4C;
	localparam logic [7:0] ERR_CTL_RESET   = 8'h20;
	localparam logic [7:0] PORT_SEL_RESET  = 8'h00;
	localparam logic [7:0] READ_ZERO       = 8'h00;

	// ************************************************
	// Field positions of the error control register
	// ************************************************
	localparam int EARLY_ACK_BIT  = 7;
	localparam int DATA_CHECK_BIT = 6;
	localparam int ENH_ERROR_BIT  = 5;
	localparam int FORCE_HI       = 4;
	localparam int FORCE_LO       = 3;
	localparam int SEL_HI         = 2;
	localparam int SEL_LO         = 0;

	// ************************************************
	// Forced error codes and byte counting
	// ************************************************
	localparam logic [1:0] FORCE_NONE      = 2'h0;
	localparam logic [1:0] FORCE_CRC       = 2'h1;
	localparam logic [1:0] FORCE_CRC_NEXT  = 2'h2;
	localparam logic [1:0] FORCE_DATA      = 2'h3;
	localparam logic [3:0] BYTE_COUNT_ZERO = 4'h0;
	localparam logic [3:0] BYTE_COUNT_ONE  = 4'h1;
	localparam logic [3:0] BYTE_COUNT_MAX  = 4'h8;

	typedef enum logic [1:0] {
		INJ_IDLE,
		INJ_ARMED,
		INJ_WAIT_NORMAL
	} inj_state_t;

	typedef struct packed {
		logic [7:0] ctl;
		inj_state_t st;
		logic [3:0] byte_cnt;
		logic       early_ack;
		logic       ack_valid;
		logic       nack;
		logic       terminate;
		logic       inj_crc;
		logic       inj_data;
	} port_state_t;

	typedef struct packed {
		logic [7:0] port_sel;
		logic [7:0] rdata;
	} top_state_t;

endpackage : ccec_pkg

/* verilog/ccec_port.sv */
/*
 * One receive port's error control register and its checking and injection logic.
 * Assumes all channel strobes are one-cycle pulses from logic on clock_i.
 */
module ccec_port
	import ccec_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] ctl_o,
	input  wire logic       remote_read_start_i,
	output logic            early_ack_o,
	input  wire logic       ack_cycle_i,
	input  wire logic [7:0] sent_byte_i,
	input  wire logic [7:0] returned_byte_i,
	input  wire logic       remote_nack_i,
	output logic            ack_valid_o,
	output logic            local_nack_o,
	input  wire logic       chan_error_i,
	output logic            terminate_o,
	input  wire logic       block_start_i,
	input  wire logic       byte_sent_i,
	input  wire logic       normal_frame_i,
	output logic            inject_crc_o,
	output logic            inject_data_o
);

	port_state_t q;
	port_state_t d;
	logic [3:0]  idx;
	logic        sel_hit;

	assign idx     = block_start_i ? BYTE_COUNT_ZERO : q.byte_cnt;
	assign sel_hit = byte_sent_i && (idx == {1'b0, q.ctl[SEL_HI:SEL_LO]});

	always_comb begin
		d = q;
		d.early_ack = remote_read_start_i && q.ctl[EARLY_ACK_BIT];
		d.ack_valid = ack_cycle_i;
		// Data mismatch turns the remote ack into a nack
		d.nack = ack_cycle_i && (remote_nack_i ||
			(q.ctl[DATA_CHECK_BIT] && (sent_byte_i != returned_byte_i)));
		d.terminate = chan_error_i && q.ctl[ENH_ERROR_BIT];
		d.inj_crc  = 1'b0;
		d.inj_data = 1'b0;
		if (block_start_i) begin
			d.byte_cnt = BYTE_COUNT_ZERO;
		end
		if (byte_sent_i && (idx != BYTE_COUNT_MAX)) begin
			d.byte_cnt = idx + BYTE_COUNT_ONE;
		end
		case (q.st)
			INJ_IDLE: begin
			end
			INJ_ARMED: begin
				// Only the first eight bytes of a block can be hit
				if (sel_hit) begin
					case (q.ctl[FORCE_HI:FORCE_LO])
						FORCE_CRC: begin
							d.inj_crc = 1'b1;
							d.st      = INJ_IDLE;
						end
						FORCE_CRC_NEXT: begin
							d.st = INJ_WAIT_NORMAL;
						end
						FORCE_DATA: begin
							d.inj_data = 1'b1;
							d.st       = INJ_IDLE;
						end
						default: begin
							d.st = INJ_IDLE;
						end
					endcase
				end
			end
			INJ_WAIT_NORMAL: begin
				if (normal_frame_i) begin
					d.inj_crc = 1'b1;
					d.st      = INJ_IDLE;
				end
			end
			default: begin
				d.st = INJ_IDLE;
			end
		endcase
		// A write arms only with a nonzero force code, else idles, and wins over a firing in the same cycle
		if (wr_i) begin
			d.ctl      = wdata_i;
			d.inj_crc  = 1'b0;
			d.inj_data = 1'b0;
			d.st = (wdata_i[FORCE_HI:FORCE_LO] != FORCE_NONE) ? INJ_ARMED : INJ_IDLE;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '{ctl: ERR_CTL_RESET, st: INJ_IDLE, byte_cnt: BYTE_COUNT_ZERO, default: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign ctl_o         = q.ctl;
	assign early_ack_o   = q.early_ack;
	assign ack_valid_o   = q.ack_valid;
	assign local_nack_o  = q.nack;
	assign terminate_o   = q.terminate;
	assign inject_crc_o  = q.inj_crc;
	assign inject_data_o = q.inj_data;

	// ************************************************
	// Assertions
	// ************************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	early_ack_gate_a: assert property (
		remote_read_start_i |=> early_ack_o == $past(ctl_o[EARLY_ACK_BIT]))
		else $error("early ack does not follow its enable");
	nack_on_mismatch_a: assert property (
		ack_cycle_i && ctl_o[DATA_CHECK_BIT] && (sent_byte_i != returned_byte_i)
		|=> ack_valid_o && local_nack_o)
		else $error("mismatch did not give a nack");
	check_off_pass_a: assert property (
		ack_cycle_i && !ctl_o[DATA_CHECK_BIT] |=> local_nack_o == $past(remote_nack_i))
		else $error("remote answer altered while check is off");
	terminate_gate_a: assert property (
		chan_error_i |=> terminate_o == $past(ctl_o[ENH_ERROR_BIT]))
		else $error("terminate does not follow enhanced enable");
	crc_on_sel_a: assert property (
		q.st == INJ_ARMED && !wr_i && sel_hit && ctl_o[FORCE_HI:FORCE_LO] == FORCE_CRC
		|=> inject_crc_o && !inject_data_o)
		else $error("crc not forced on selected byte");
	data_on_sel_a: assert property (
		q.st == INJ_ARMED && !wr_i && sel_hit && ctl_o[FORCE_HI:FORCE_LO] == FORCE_DATA
		|=> inject_data_o && !inject_crc_o)
		else $error("data error not forced on selected byte");
	single_shot_a: assert property (
		inject_crc_o || inject_data_o |-> q.st == INJ_IDLE)
		else $error("injector still armed after firing");
	idle_quiet_a: assert property (
		q.st == INJ_IDLE && !wr_i |=> !inject_crc_o && !inject_data_o)
		else $error("injection without a new arm");
	ctl_hold_a: assert property (
		!wr_i |=> $stable(ctl_o))
		else $error("control register changed without a write");

	crc_next_c: cover property (q.st == INJ_WAIT_NORMAL ##[1:20] inject_crc_o);
	data_inj_c: cover property (wr_i ##[1:20] inject_data_o);
	nack_c:     cover property (ack_cycle_i && !remote_nack_i ##1 local_nack_o);

endmodule : ccec_port

/* verilog/control_channel_error_ctl.sv */
/*
 * Per-port control channel error checking and error injection control.
 * Assumes register accesses arrive as one-cycle strobes from the local I2C target
 * logic, and channel events as one-cycle pulses on clock_i.
 */

// Summary of operation
// - Enable bit 7 makes an internal ack at each remote read start.
// - Enable bit 6 checks data returned during the acknowledge cycle.
// - A returned data mismatch turns the remote ack into a local nack.
// - Bit 5, reset one, terminates transactions on detected channel errors.
// - Bits 4:3 pick none, crc, crc on next normal frame, or data error.
// - A nonzero force code yields exactly one error, never a stream.
// - Bits 2:0 pick which of the first eight forward bytes is hit.
// - One register per receive port, reached through the port select register.
module control_channel_error_ctl
	import ccec_pkg::*;
#(
	parameter int NUM_PORTS = 4
) (
	input  wire logic                      clock_i,
	input  wire logic                      rst_i,
	input  wire logic                      reg_wr_i,
	input  wire logic                      reg_rd_i,
	input  wire logic [7:0]                reg_addr_i,
	input  wire logic [7:0]                reg_wdata_i,
	output logic      [7:0]                reg_rdata_o,
	input  wire logic [NUM_PORTS-1:0]      remote_read_start_i,
	output logic      [NUM_PORTS-1:0]      early_ack_o,
	input  wire logic [NUM_PORTS-1:0]      ack_cycle_i,
	input  wire logic [NUM_PORTS-1:0][7:0] sent_byte_i,
	input  wire logic [NUM_PORTS-1:0][7:0] returned_byte_i,
	input  wire logic [NUM_PORTS-1:0]      remote_nack_i,
	output logic      [NUM_PORTS-1:0]      ack_valid_o,
	output logic      [NUM_PORTS-1:0]      local_nack_o,
	input  wire logic [NUM_PORTS-1:0]      chan_error_i,
	output logic      [NUM_PORTS-1:0]      terminate_o,
	input  wire logic [NUM_PORTS-1:0]      block_start_i,
	input  wire logic [NUM_PORTS-1:0]      byte_sent_i,
	input  wire logic [NUM_PORTS-1:0]      normal_frame_i,
	output logic      [NUM_PORTS-1:0]      inject_crc_o,
	output logic      [NUM_PORTS-1:0]      inject_data_o,
	output logic      [NUM_PORTS-1:0]      early_ack_en_o,
	output logic      [NUM_PORTS-1:0]      returned_data_check_en_o,
	output logic      [NUM_PORTS-1:0]      enhanced_error_check_en_o
);

	localparam int SEL_W = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

	top_state_t                  q;
	top_state_t                  d;
	logic [NUM_PORTS-1:0][7:0]   ctl;
	logic [NUM_PORTS-1:0]        port_wr;
	logic [SEL_W-1:0]            sel;

	// ************************************************
	// Port select and read path
	// ************************************************
	// Only the low bits index a port; a value past the last port reaches none
	assign sel = q.port_sel[SEL_W-1:0];

	always_comb begin
		d = q;
		if (reg_wr_i && reg_addr_i == PORT_SEL_OFFSET) begin
			d.port_sel = reg_wdata_i;
		end
		if (reg_rd_i) begin
			if (reg_addr_i == ERR_CTL_OFFSET && int'(sel) < NUM_PORTS &&
				q.port_sel < 8'(NUM_PORTS)) begin
				d.rdata = ctl[sel];
			end else if (reg_addr_i == PORT_SEL_OFFSET) begin
				d.rdata = q.port_sel;
			end else begin
				d.rdata = READ_ZERO;
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '{port_sel: PORT_SEL_RESET, rdata: READ_ZERO};
		end else begin
			q <= d;
		end
	end

	assign reg_rdata_o = q.rdata;

	// ************************************************
	// Per-port instances
	// ************************************************
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port
			// Writes land only in the selected port's copy
			assign port_wr[p] = reg_wr_i && reg_addr_i == ERR_CTL_OFFSET &&
				q.port_sel == 8'(p);

			ccec_port u_port (
				.clock_i             (clock_i),
				.rst_i               (rst_i),
				.wr_i                (port_wr[p]),
				.wdata_i             (reg_wdata_i),
				.ctl_o               (ctl[p]),
				.remote_read_start_i (remote_read_start_i[p]),
				.early_ack_o         (early_ack_o[p]),
				.ack_cycle_i         (ack_cycle_i[p]),
				.sent_byte_i         (sent_byte_i[p]),
				.returned_byte_i     (returned_byte_i[p]),
				.remote_nack_i       (remote_nack_i[p]),
				.ack_valid_o         (ack_valid_o[p]),
				.local_nack_o        (local_nack_o[p]),
				.chan_error_i        (chan_error_i[p]),
				.terminate_o         (terminate_o[p]),
				.block_start_i       (block_start_i[p]),
				.byte_sent_i         (byte_sent_i[p]),
				.normal_frame_i      (normal_frame_i[p]),
				.inject_crc_o        (inject_crc_o[p]),
				.inject_data_o       (inject_data_o[p])
			);

			// Enable levels come straight from the port's register flops
			assign early_ack_en_o[p]            = ctl[p][EARLY_ACK_BIT];
			assign returned_data_check_en_o[p]  = ctl[p][DATA_CHECK_BIT];
			assign enhanced_error_check_en_o[p] = ctl[p][ENH_ERROR_BIT];

			// Per-port register and channel checks, one set for every receive port
			own_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
				!port_wr[p] |=> $stable(ctl[p]))
				else $error("port register changed without its own write");
			en_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
				port_wr[p] |=> early_ack_en_o[p] == $past(reg_wdata_i[EARLY_ACK_BIT]) &&
					returned_data_check_en_o[p] == $past(reg_wdata_i[DATA_CHECK_BIT]) &&
					enhanced_error_check_en_o[p] == $past(reg_wdata_i[ENH_ERROR_BIT]))
				else $error("enable levels do not follow the written bits");
			early_cause_a: assert property (@(posedge clock_i) disable iff (rst_i)
				early_ack_o[p] |-> $past(remote_read_start_i[p]))
				else $error("internal ack without a remote read start");
			early_off_a: assert property (@(posedge clock_i) disable iff (rst_i)
				remote_read_start_i[p] && !early_ack_en_o[p] |=> !early_ack_o[p])
				else $error("internal ack while disabled");
			answer_follow_a: assert property (@(posedge clock_i) disable iff (rst_i)
				ack_cycle_i[p] |=> ack_valid_o[p])
				else $error("ack cycle gave no local answer");
			answer_cause_a: assert property (@(posedge clock_i) disable iff (rst_i)
				ack_valid_o[p] |-> $past(ack_cycle_i[p]))
				else $error("local answer without an ack cycle");
			nack_pair_a: assert property (@(posedge clock_i) disable iff (rst_i)
				local_nack_o[p] |-> ack_valid_o[p])
				else $error("nack without a local answer");
			// A nack needs a remote nack or an enabled mismatch behind it
			nack_cause_a: assert property (@(posedge clock_i) disable iff (rst_i)
				local_nack_o[p] |-> $past(remote_nack_i[p] ||
					(returned_data_check_en_o[p] && sent_byte_i[p] != returned_byte_i[p])))
				else $error("nack without a cause");
			term_cause_a: assert property (@(posedge clock_i) disable iff (rst_i)
				terminate_o[p] |-> $past(chan_error_i[p]))
				else $error("terminate without a channel error");
			term_off_a: assert property (@(posedge clock_i) disable iff (rst_i)
				chan_error_i[p] && !enhanced_error_check_en_o[p] |=> !terminate_o[p])
				else $error("terminate while enhanced checking is off");
			data_cause_a: assert property (@(posedge clock_i) disable iff (rst_i)
				inject_data_o[p] |-> $past(byte_sent_i[p]))
				else $error("data error forced without a sent byte");
			crc_cause_a: assert property (@(posedge clock_i) disable iff (rst_i)
				inject_crc_o[p] |-> $past(byte_sent_i[p] || normal_frame_i[p]))
				else $error("crc error forced without a frame");
			one_error_a: assert property (@(posedge clock_i) disable iff (rst_i)
				!(inject_crc_o[p] && inject_data_o[p]))
				else $error("crc and data errors forced together");
		end
	endgenerate

	// ************************************************
	// Assertions
	// ************************************************
	sel_write_only_a: assert property (@(posedge clock_i) disable iff (rst_i)
		reg_wr_i && reg_addr_i == ERR_CTL_OFFSET && q.port_sel < 8'(NUM_PORTS)
		|=> ctl[$past(sel)] == $past(reg_wdata_i))
		else $error("write missed the selected port");
	read_back_a: assert property (@(posedge clock_i) disable iff (rst_i)
		reg_rd_i && !reg_wr_i && reg_addr_i == PORT_SEL_OFFSET
		|=> reg_rdata_o == $past(q.port_sel))
		else $error("port select read back wrong");

	// ************************************************
	// Register path checks
	// ************************************************
	sel_store_a: assert property (@(posedge clock_i) disable iff (rst_i)
		reg_wr_i && reg_addr_i == PORT_SEL_OFFSET |=> q.port_sel == $past(reg_wdata_i))
		else $error("port select write not stored");
	sel_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
		reg_rd_i && reg_addr_i == ERR_CTL_OFFSET && q.port_sel < 8'(NUM_PORTS)
		|=> reg_rdata_o == $past(ctl[sel]))
		else $error("error control read from the wrong port");
	// A port select past the last port must not alias onto a real port
	far_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
		reg_rd_i && reg_addr_i == ERR_CTL_OFFSET && q.port_sel >= 8'(NUM_PORTS)
		|=> reg_rdata_o == READ_ZERO)
		else $error("read through a missing port was not zero");
	far_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
		reg_wr_i && reg_addr_i == ERR_CTL_OFFSET && q.port_sel >= 8'(NUM_PORTS)
		|=> $stable(ctl))
		else $error("write through a missing port reached a register");
	unmapped_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
		reg_rd_i && reg_addr_i != ERR_CTL_OFFSET && reg_addr_i != PORT_SEL_OFFSET
		|=> reg_rdata_o == READ_ZERO)
		else $error("unmapped offset read was not zero");
	// Read data stays put so slow bus logic may sample it late
	rdata_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
		!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data changed without a read");
	one_port_a: assert property (@(posedge clock_i) disable iff (rst_i)
		$onehot0(port_wr))
		else $error("one write reached several ports");

	port_switch_c: cover property (@(posedge clock_i) disable iff (rst_i)
		reg_wr_i && reg_addr_i == PORT_SEL_OFFSET ##[1:10] reg_wr_i && reg_addr_i == ERR_CTL_OFFSET);
	far_port_c: cover property (@(posedge clock_i) disable iff (rst_i)
		reg_rd_i && reg_addr_i == ERR_CTL_OFFSET && q.port_sel >= 8'(NUM_PORTS));

endmodule : control_channel_error_ctl

/* test/remote_serializer_model.sv */
/*
 * Behavioural remote serializer that answers control channel bytes in the ack cycle.
 * Assumes the bench calls ack_byte from its main process at a falling clock edge.
 */
module remote_serializer_model (
	input  wire logic       clock_i,
	output logic            ack_cycle_o,
	output logic      [7:0] sent_byte_o,
	output logic      [7:0] returned_byte_o,
	output logic            remote_nack_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		ack_cycle_o     = 1'b0;
		sent_byte_o     = 8'h00;
		returned_byte_o = 8'hFF;
		remote_nack_o   = 1'b0;
	end

	// Faulty echo only when the bench asks for it
	task automatic ack_byte(input logic [7:0] b, input logic bad, input logic nk);
		ack_cycle_o     = 1'b1;
		sent_byte_o     = b;
		returned_byte_o = bad ? ~b : b;
		remote_nack_o   = nk;
		@(negedge clock_i);
		ack_cycle_o     = 1'b0;
		// Released lines drive the inverse of the sent byte and of the nack answer
		returned_byte_o = ~b;
		remote_nack_o   = ~nk;
	endtask : ack_byte
endmodule : remote_serializer_model

/* test/control_channel_error_ctl_tb.sv */
/*
 * Self-checking bench for the control channel error control block, two ports.
 * Assumes registered one-cycle answers; inputs change at the falling edge.
 */
module control_channel_error_ctl_tb
	import ccec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int NP = 2;
	localparam logic [3:0] CK [5] = '{4'b0100, 4'b0011, 4'b1101, 4'b1000, 4'b1011};
	logic                clock_i, rst_i, reg_wr_i, reg_rd_i;
	logic     [7:0]      reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic     [NP-1:0]   rrs, eack, ackv, lnack, cerr, term, bstart, bsent, nframe;
	logic     [NP-1:0]   icrc, idata, en7, en6, en5;
	wire      [NP-1:0]   ackc, rnack;
	wire [NP-1:0][7:0]   sent, ret;
	int                  fail_count, samples_checked;

	control_channel_error_ctl #(.NUM_PORTS(NP)) uut (
		.clock_i(clock_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.remote_read_start_i(rrs), .early_ack_o(eack), .ack_cycle_i(ackc),
		.sent_byte_i(sent), .returned_byte_i(ret), .remote_nack_i(rnack),
		.ack_valid_o(ackv), .local_nack_o(lnack), .chan_error_i(cerr), .terminate_o(term),
		.block_start_i(bstart), .byte_sent_i(bsent), .normal_frame_i(nframe),
		.inject_crc_o(icrc), .inject_data_o(idata), .early_ack_en_o(en7),
		.returned_data_check_en_o(en6), .enhanced_error_check_en_o(en5)
	);

	for (genvar p = 0; p < NP; p++) begin : g_far
		remote_serializer_model mdl (.clock_i(clock_i), .ack_cycle_o(ackc[p]),
			.sent_byte_o(sent[p]), .returned_byte_o(ret[p]), .remote_nack_o(rnack[p]));
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr_i    = 1'b1;
		reg_addr_i  = a;
		reg_wdata_i = d;
		@(negedge clock_i);
		reg_wr_i    = 1'b0;
		// Idle cycle so a following call never retoggles a strobe in one step
		@(negedge clock_i);
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
		reg_rd_i   = 1'b1;
		reg_addr_i = a;
		@(negedge clock_i);
		reg_rd_i   = 1'b0;
		check(reg_rdata_o, exp);
		@(negedge clock_i);
	endtask : reg_rd

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		for (int p = 0; p < NP; p++) begin
			reg_wr(PORT_SEL_OFFSET, 8'(p));
			reg_rd(ERR_CTL_OFFSET, ERR_CTL_RESET);
		end
		check({2'h0, en7, en6, en5}, 8'h03);
		reg_rd(8'h45, READ_ZERO);
		reg_wr(ERR_CTL_OFFSET, 8'h47);
		reg_wr(PORT_SEL_OFFSET, 8'h00);
		reg_wr(ERR_CTL_OFFSET, 8'hC5);
		reg_rd(ERR_CTL_OFFSET, 8'hC5);
		check({2'h0, en7, en6, en5}, 8'h1C);
		reg_wr(PORT_SEL_OFFSET, 8'h02);
		reg_rd(ERR_CTL_OFFSET, READ_ZERO);
		reg_rd(PORT_SEL_OFFSET, 8'h02);
		reg_wr(PORT_SEL_OFFSET, 8'h01);
		reg_rd(ERR_CTL_OFFSET, 8'h47);
		reg_wr(PORT_SEL_OFFSET, 8'h00);
	endtask : t_regs

	// Early ack on port 0 checked with its enable off, then on; port 1 stays disabled
	task automatic t_early();
		for (int e = 0; e < 2; e++) begin
			reg_wr(ERR_CTL_OFFSET, e ? 8'hA0 : 8'h20);
			rrs = 2'b11;
			@(negedge clock_i);
			rrs = 2'b00;
			check({6'h00, eack}, 8'(e));
			@(negedge clock_i);
			check({6'h00, eack}, 8'h00);
		end
	endtask : t_early

	task automatic t_check();
		for (int i = 0; i < 5; i++) begin
			reg_wr(ERR_CTL_OFFSET, CK[i][3] ? 8'h60 : 8'h20);
			g_far[0].mdl.ack_byte(8'h5A + 8'(i), CK[i][2], CK[i][1]);
			check({4'h0, ackv, lnack}, {4'h0, 2'b01, 1'b0, CK[i][0]});
		end
	endtask : t_check

	task automatic t_term();
		for (int e = 0; e < 2; e++) begin
			reg_wr(ERR_CTL_OFFSET, e ? 8'h20 : 8'h00);
			cerr = 2'b01;
			@(negedge clock_i);
			cerr = 2'b00;
			check({6'h00, term}, 8'(e));
		end
	endtask : t_term

	// Second block checks the injector stays idle without a rewrite
	task automatic t_inject(input logic [1:0] code, input logic [2:0] sel);
		logic hit;
		reg_wr(ERR_CTL_OFFSET, {3'b001, code, sel});
		for (int blk = 0; blk < 2; blk++) begin
			for (int b = 0; b < 10; b++) begin
				hit       = (blk == 0) && (b == 32'(sel));
				bstart[0] = (b == 0);
				bsent[0]  = 1'b1;
				@(negedge clock_i);
				bstart[0] = 1'b0;
				bsent[0]  = 1'b0;
				nframe[0] = 1'b1;
				check({4'h0, icrc, idata}, {5'h00, code == FORCE_CRC && hit, 1'b0,
					code == FORCE_DATA && hit});
				@(negedge clock_i);
				nframe[0] = 1'b0;
				check({4'h0, icrc, idata}, {5'h00, code == FORCE_CRC_NEXT && hit, 2'h0});
			end
		end
	endtask : t_inject

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	initial begin
		#50us;
		fail_count++;
		conclude();
	end

	initial begin
		rst_i           = 1'b1;
		reg_wr_i        = 1'b0;
		reg_rd_i        = 1'b0;
		reg_addr_i      = 8'h00;
		reg_wdata_i     = 8'h00;
		{rrs, cerr}     = 4'h0;
		{bstart, bsent} = 4'h0;
		nframe          = 2'h0;
		fail_count      = 0;
		samples_checked = 0;
		repeat (8) @(negedge clock_i);
		rst_i = 1'b0;
		t_regs();
		t_early();
		t_check();
		t_term();
		t_inject(FORCE_CRC, 3'h0);
		t_inject(FORCE_DATA, 3'h7);
		t_inject(FORCE_CRC_NEXT, 3'h3);
		t_inject(FORCE_CRC, 3'h7);
		t_inject(FORCE_NONE, 3'h2);
		conclude();
	end
endmodule : control_channel_error_ctl_tb
